/* File: design/bpc_port.sv */
// bpc_port.sv: eight-pin bidirectional port with change and edge interrupt flags
// assumes: single 200 MHz clock, pins asynchronous, AXI4-Lite master one op at a time
// What this block does
// [R01] eight pins, each input or output
// [R02] direction one makes pin input, hi-z
// [R03] direction zero drives the output latch
// [R04] option bit 7 low enables all pull-ups
// [R05] output pins never get a pull-up
// [R06] pull-ups off after reset
// [R07] watch upper four input pins only
// [R08] compare against value captured at last port read or write
// [R09] OR mismatches into change flag bit 0
// [R10] active change interrupt wakes from sleep
// [R11] port read or write refreshes reference
// [R12] mismatch keeps setting flag; read before clear
// [R13] software should avoid polling the port
// [R14] pin 0 edge interrupt, edge by option bit 6
// [R15] peripheral override forces pin direction
// [R16] software avoids direction read-modify-write under override
// [R17] direction bit 2 reads back serial output enable
// [R18] flags set regardless of global enable
// [R19] pins synchronised before edge and mismatch detection
// [R20] selected edge sets external flag bit 1
`include "bpc_consts.svh"
module bpc_port (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // port pins, split into input, output and enable
  input  wire logic [7:0]  second_port_in,
  output logic [7:0]       second_port_out,
  output logic [7:0]       second_port_oe,
  output logic [7:0]       pullup_en,
  // peripheral direction overrides
  input  wire logic [7:0]  periph_override,
  input  wire logic [7:0]  periph_dir,
  input  wire logic        sync_serial_port_oe,
  input  wire logic        sync_serial_port_ctl,
  // interrupt and wake
  output logic             irq_request,
  output logic             wake_request
);

  // decoding of a byte address, used by both read and write paths
  function automatic bpc_pkg::bpc_sel_t decode(input logic [11:0] addr);
    unique case (addr)
      `BPC_ADDR_PORT:   decode = bpc_pkg::BPC_SEL_PORT;
      `BPC_ADDR_DIR:    decode = bpc_pkg::BPC_SEL_DIR;
      `BPC_ADDR_OPTION: decode = bpc_pkg::BPC_SEL_OPTION;
      `BPC_ADDR_INTCTL: decode = bpc_pkg::BPC_SEL_INTCTL;
      default:          decode = bpc_pkg::BPC_SEL_NONE;
    endcase
  endfunction : decode

  // software-visible state
  logic [7:0] out_latch;         // output latch
  logic [7:0] port_direction;    // one = input
  logic [7:0] option_reg;        // pull-up and edge controls
  logic [7:0] interrupt_control; // enables and flags
  // pin synchronisers, first stage read only by second
  logic [7:0] pin_meta;
  logic [7:0] pin_sync;
  logic       ext_prev;          // previous synchronised pin 0
  logic [3:0] change_ref;        // reference captured on port access
  // axi channel holding state
  logic        aw_held;
  logic [11:0] aw_addr;
  logic        w_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  // effective direction after overrides; the serial enable only alters the readback
  logic [7:0] eff_dir;
  logic [7:0] dir_readback;
  always_comb begin
    eff_dir = port_direction;
    for (int i = 0; i < 8; i++) begin
      if (periph_override[i]) begin
        eff_dir[i] = periph_dir[i]; // [R15]
      end
    end
    dir_readback = eff_dir;
    if (sync_serial_port_ctl) begin
      dir_readback[`BPC_SDO_PIN] = ~sync_serial_port_oe; // [R17]
    end
  end

  // pin drivers and pull-ups per pin
  for (genvar g = 0; g < 8; g++) begin : g_pin
    assign second_port_oe[g]  = ~eff_dir[g]; // [R01] [R02]
    assign second_port_out[g] = out_latch[g]; // [R03]
    assign pullup_en[g] = ~option_reg[`BPC_OPT_PULLUP_N] & eff_dir[g]; // [R04] [R05] [R06]
  end

  // synchronise the pins before any detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
      ext_prev <= 1'b0;
    end else begin
      pin_meta <= second_port_in; // [R19]
      pin_sync <= pin_meta;
      ext_prev <= pin_sync[0];
    end
  end

  // pin readback: inputs from pins, outputs from latch
  logic [7:0] port_read;
  assign port_read = (pin_sync & eff_dir) | (out_latch & ~eff_dir);

  // detection terms
  logic [3:0] mismatch;
  logic       change_hit;
  logic       ext_edge;
  assign mismatch   = (pin_sync[7:4] ^ change_ref) & eff_dir[7:4]; // [R07] [R08]
  assign change_hit = |mismatch; // [R09]
  assign ext_edge   = option_reg[`BPC_OPT_EDGE] ? (pin_sync[0] & ~ext_prev)
                                                : (~pin_sync[0] & ext_prev); // [R14]

  // bus handshakes: accept address and data in either order
  logic wr_go;
  logic rd_go;
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_go = aw_held & w_held & ~s_axi_bvalid;
  assign rd_go = s_axi_arvalid & s_axi_arready;

  bpc_pkg::bpc_sel_t wsel;
  bpc_pkg::bpc_sel_t rsel;
  assign wsel = decode(aw_addr);
  assign rsel = decode(s_axi_araddr);

  // write channel capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
      w_held  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `BPC_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wsel == bpc_pkg::BPC_SEL_NONE) ? `BPC_RESP_SLVERR : `BPC_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // byte-lane write enable for the low byte
  logic wr_lo;
  assign wr_lo = wr_go & w_strb[0];

  // control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_latch      <= `BPC_RST_LATCH;
      port_direction <= `BPC_RST_DIR;
      option_reg     <= `BPC_RST_OPTION;
    end else if (wr_lo) begin
      if (wsel == bpc_pkg::BPC_SEL_PORT) begin
        out_latch <= w_data[7:0];
      end
      if (wsel == bpc_pkg::BPC_SEL_DIR) begin
        port_direction <= w_data[7:0];
      end
      if (wsel == bpc_pkg::BPC_SEL_OPTION) begin
        option_reg <= w_data[7:0];
      end
    end
  end

  // change reference refreshed by any port access
  logic port_access;
  assign port_access = (wr_go && wsel == bpc_pkg::BPC_SEL_PORT)
                     || (rd_go && rsel == bpc_pkg::BPC_SEL_PORT);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      change_ref <= 4'h0;
    end else if (port_access) begin
      change_ref <= pin_sync[7:4]; // [R11]
    end
  end

  // interrupt control: flags set on events, set beats software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interrupt_control <= `BPC_RST_INTCTL;
    end else begin
      if (wr_lo && wsel == bpc_pkg::BPC_SEL_INTCTL) begin
        interrupt_control <= w_data[7:0];
      end
      if (change_hit) begin
        interrupt_control[`BPC_IC_CHG_FLAG] <= 1'b1; // [R12] [R18]
      end
      if (ext_edge) begin
        interrupt_control[`BPC_IC_EXT_FLAG] <= 1'b1; // [R20] [R18]
      end
    end
  end

  // gated interrupt and wake outputs
  logic chg_active;
  logic ext_active;
  assign chg_active = interrupt_control[`BPC_IC_CHG_FLAG] & interrupt_control[`BPC_IC_CHG_EN];
  assign ext_active = interrupt_control[`BPC_IC_EXT_FLAG] & interrupt_control[`BPC_IC_EXT_EN];
  assign wake_request = chg_active | ext_active; // [R10]
  assign irq_request  = wake_request & interrupt_control[`BPC_IC_GIE];

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `BPC_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `BPC_RESP_OKAY;
      unique case (rsel)
        bpc_pkg::BPC_SEL_PORT:   s_axi_rdata <= {24'h00_0000, port_read};
        bpc_pkg::BPC_SEL_DIR:    s_axi_rdata <= {24'h00_0000, dir_readback};
        bpc_pkg::BPC_SEL_OPTION: s_axi_rdata <= {24'h00_0000, option_reg};
        bpc_pkg::BPC_SEL_INTCTL: s_axi_rdata <= {24'h00_0000, interrupt_control};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `BPC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // pull-ups follow control and direction
  pullup_rule_a: assert property (@(posedge aclk) disable iff (!aresetn)
    pullup_en == ({8{~option_reg[`BPC_OPT_PULLUP_N]}} & eff_dir))
    else $error("pull-up enable wrong"); // [R04]
  // output pins never pulled up
  pullup_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (pullup_en & second_port_oe) == 8'h00)
    else $error("pull-up on output pin"); // [R05]
  // pull-ups off right after reset
  pullup_reset_a: assert property (@(posedge aclk)
    $rose(aresetn) |-> pullup_en == 8'h00)
    else $error("pull-up on after reset"); // [R06]
  // driver enable mirrors direction
  drive_dir_a: assert property (@(posedge aclk) disable iff (!aresetn)
    second_port_oe == ~eff_dir && second_port_out == out_latch)
    else $error("pin driver wrong"); // [R02]
  // mismatch on a watched input sets the flag next cycle
  change_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    change_hit |=> interrupt_control[`BPC_IC_CHG_FLAG])
    else $error("change flag not set"); // [R09]
  // no mismatch while all four upper pins are configured as outputs
  change_excl_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (eff_dir[7:4] == 4'h0) |-> !change_hit)
    else $error("output pin in change compare"); // [R07]
  // port access loads the reference from the synchronised upper pins one cycle later
  ref_refresh_a: assert property (@(posedge aclk) disable iff (!aresetn)
    port_access |=> change_ref == $past(pin_sync[7:4]))
    else $error("reference not refreshed"); // [R11]
  // rising edge selected sets the external flag
  ext_rise_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (option_reg[`BPC_OPT_EDGE] && pin_sync[0] && !ext_prev) |=>
      interrupt_control[`BPC_IC_EXT_FLAG])
    else $error("external flag missed"); // [R20]
  // flag set even with global enable clear
  flag_nogie_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ext_edge && !interrupt_control[`BPC_IC_GIE]) |=> interrupt_control[`BPC_IC_EXT_FLAG])
    else $error("flag gated by global enable"); // [R18]
  // synchronised pin follows the input by two cycles
  pin_sync_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ##2 pin_sync == $past(second_port_in, 2))
    else $error("synchroniser depth wrong"); // [R19]

endmodule : bpc_port

/* File: design/bpc_consts.svh */
// bpc_consts.svh: offsets, field positions, reset values of the change-irq port
// assumes: included by bare name from the package and the design module
`ifndef BPC_CONSTS_SVH
`define BPC_CONSTS_SVH
// register byte addresses (indices scaled by four, some indices not word multiples)
`define BPC_IDX_INTCTL     8'h0b
`define BPC_IDX_DIR        8'h86
`define BPC_IDX_OPTION     8'h81
`define BPC_IDX_PORT       8'h06
`define BPC_ADDR_INTCTL    12'h02c
`define BPC_ADDR_DIR       12'h218
`define BPC_ADDR_OPTION    12'h204
`define BPC_ADDR_PORT      12'h018
// field positions
`define BPC_OPT_PULLUP_N   7
`define BPC_OPT_EDGE       6
`define BPC_IC_GIE         7
`define BPC_IC_EXT_EN      4
`define BPC_IC_CHG_EN      3
`define BPC_IC_EXT_FLAG    1
`define BPC_IC_CHG_FLAG    0
`define BPC_SDO_PIN        2
// reset values
`define BPC_RST_DIR        8'hff
`define BPC_RST_OPTION     8'hff
`define BPC_RST_INTCTL     8'h00
`define BPC_RST_LATCH      8'h00
// axi answers
`define BPC_RESP_OKAY      2'b00
`define BPC_RESP_SLVERR    2'b10
`endif

/* File: design/bpc_pkg.sv */
// bpc_pkg.sv: types shared by the change-irq port
// assumes: nothing beyond the constants header
`include "bpc_consts.svh"
package bpc_pkg;
  // register selector decoded from a byte address
  typedef enum logic [2:0] {
    BPC_SEL_NONE   = 3'b000,
    BPC_SEL_PORT   = 3'b001,
    BPC_SEL_DIR    = 3'b011,
    BPC_SEL_OPTION = 3'b010,
    BPC_SEL_INTCTL = 3'b110
  } bpc_sel_t;
endpackage : bpc_pkg

/* File: testbench/bpc_board.sv */
// bpc_board.sv: board side of the eight port pins
// assumes: the block's driver wins over the board, the board over the pull-up
module bpc_board (
  // clock
  input  wire logic       aclk,
  // block side of the pins
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pullup_en,
  // board drive, one enable bit per pin
  input  wire logic [7:0] drv,
  input  wire logic [7:0] drv_en,
  // resolved level fed back to the block
  output logic [7:0]      pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // floating pins show a pattern that flips every cycle
  logic [7:0] float_pat = 8'h55;
  always @(posedge aclk) begin
    float_pat <= ~float_pat;
  end
  // resolve each pin from all parties' enables
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : drv_en[i] ? drv[i] :
                  pullup_en[i] ? 1'b1 : float_pat[i];
    end
  end
endmodule : bpc_board

/* File: testbench/bpc_port_bench.sv */
// bpc_port_bench.sv: self-checking bench for the change-irq port
// assumes: design files and bpc_board compiled first, 200 MHz clock
`include "bpc_consts.svh"
module bpc_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // clock, reset and axi master side
  logic        aclk, aresetn;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp, resp;
  // pins, board drive and overrides
  logic [7:0]  pin_in, pin_out, pin_oe, pullup_en, ovr, ovr_dir, drv, drv_en;
  logic        ssp_oe, ssp_ctl, irq, wake;
  int          failures, n_checks;

  bpc_port i_bpc_port (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .second_port_in(pin_in),
    .second_port_out(pin_out), .second_port_oe(pin_oe), .pullup_en(pullup_en),
    .periph_override(ovr), .periph_dir(ovr_dir), .sync_serial_port_oe(ssp_oe),
    .sync_serial_port_ctl(ssp_ctl), .irq_request(irq), .wake_request(wake));

  bpc_board i_bpc_board (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_en(pullup_en), .drv(drv), .drv_en(drv_en), .pin_in(pin_in));

  // compare and count
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // one axi write, both channels offered together
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awready && !aw_done) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !w_done) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    resp = bresp;
  endtask : wr

  // one axi read, data compared against the expectation
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    resp = rresp;
    chk(n, e, rdata);
  endtask : rd

  // verdict and end of run
  task automatic stop_test();
    if (failures == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  // clock at 200 MHz
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // watchdog, the whole sequence needs well under 1000 cycles
  initial begin
    repeat (5000) @(posedge aclk);
    failures++;
    stop_test();
  end

  // main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, ssp_oe, ssp_ctl} = '0;
    {awaddr, araddr, wdata, ovr, ovr_dir, drv} = '0;
    // master keeps both response readies up, so a back-to-back call never re-drives them
    {bready, rready} = 2'b11;
    wstrb = 4'hf;
    drv_en = 8'hff;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("pullup_rst", 0, pullup_en);
    chk("oe_rst", 0, pin_oe);
    rd(`BPC_ADDR_DIR, 32'h0000_00ff, "dir_rst");
    rd(`BPC_ADDR_INTCTL, 32'h0000_0000, "intctl_rst");
    rd(`BPC_ADDR_OPTION, 32'h0000_00ff, "option_rst");
    // two outputs on top, the rest inputs
    wr(`BPC_ADDR_DIR, 8'h3f);
    wr(`BPC_ADDR_PORT, 8'ha5);
    chk("oe", 32'h0000_00c0, pin_oe);
    chk("out_hi", 2'b10, pin_out[7:6]);
    // pull-ups on, board lets go of pin 3
    wr(`BPC_ADDR_OPTION, 8'h7f);
    chk("pullup", 32'h0000_003f, pullup_en);
    drv_en <= 8'hf7;
    // let the pulled-up level pass the two synchroniser stages
    repeat (3) @(posedge aclk);
    rd(`BPC_ADDR_PORT, 32'h0000_0088, "port_rd");
    drv_en <= 8'hff;
    wr(`BPC_ADDR_INTCTL, 8'h00);
    // watched input changes with everything masked, port left unpolled meanwhile
    drv <= 8'h10;
    repeat (4) @(posedge aclk);
    rd(`BPC_ADDR_INTCTL, 32'h0000_0001, "chg_flag");
    chk("wake_masked", 0, wake);
    wr(`BPC_ADDR_INTCTL, 8'h00);
    rd(`BPC_ADDR_INTCTL, 32'h0000_0001, "chg_held");
    rd(`BPC_ADDR_PORT, 32'h0000_0090, "port_ref");
    wr(`BPC_ADDR_INTCTL, 8'h00);
    rd(`BPC_ADDR_INTCTL, 32'h0000_0000, "chg_clr");
    // lower pins change, no flag
    drv <= 8'h1e;
    repeat (4) @(posedge aclk);
    rd(`BPC_ADDR_INTCTL, 32'h0000_0000, "chg_low");
    // enabled change wakes, global enable raises the request
    wr(`BPC_ADDR_INTCTL, 8'h08);
    drv <= 8'h3e;
    repeat (4) @(posedge aclk);
    chk("wake", 1, wake);
    chk("irq_off", 0, irq);
    wr(`BPC_ADDR_INTCTL, 8'h88);
    chk("irq", 1, irq);
    rd(`BPC_ADDR_PORT, 32'h0000_00be, "port_rd2");
    wr(`BPC_ADDR_INTCTL, 8'h00);
    // pin 0 rising edge selected
    drv <= 8'h3f;
    repeat (4) @(posedge aclk);
    rd(`BPC_ADDR_INTCTL, 32'h0000_0002, "ext_rise");
    // falling edge selected
    wr(`BPC_ADDR_OPTION, 8'h3f);
    wr(`BPC_ADDR_INTCTL, 8'h00);
    drv <= 8'h3e;
    repeat (4) @(posedge aclk);
    rd(`BPC_ADDR_INTCTL, 32'h0000_0002, "ext_fall");
    wr(`BPC_ADDR_INTCTL, 8'h00);
    drv <= 8'h3f;
    repeat (4) @(posedge aclk);
    rd(`BPC_ADDR_INTCTL, 32'h0000_0000, "ext_wrong");
    // peripheral forces pin 0 to drive, direction register left alone meanwhile
    ovr <= 8'h01;
    @(posedge aclk);
    chk("oe_ovr", 32'h0000_00c1, pin_oe);
    ovr <= 8'h00;
    // serial output enable seen on direction bit 2
    ssp_ctl <= 1'b1;
    ssp_oe <= 1'b1;
    rd(`BPC_ADDR_DIR, 32'h0000_003b, "dir_ssp");
    ssp_oe <= 1'b0;
    rd(`BPC_ADDR_DIR, 32'h0000_003f, "dir_ssp_off");
    ssp_ctl <= 1'b0;
    // unmapped place answers with an error
    rd(12'h100, 32'h0000_0000, "unmapped");
    chk("rresp", `BPC_RESP_SLVERR, resp);
    wr(12'h100, 8'h55);
    chk("bresp", `BPC_RESP_SLVERR, resp);
    stop_test();
  end
endmodule : bpc_port_bench
